// file: rsmr_top.v
// Purpose: Reset source recording, software reset and low memory remap.
// Assumes: Power-on reset drives reset_i; other sources are one-cycle pulses.
// Notes:   Status register survives every reset except power-on.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`include "rsmr_defines.vh"
module rsmr_top (
   input  wire                    core_clk_i,
   input  wire                    reset_i,
   input  wire [`RSMR_ADDR_W-1:0] reg_addr_i,
   input  wire [7:0]              reg_wdata_i,
   input  wire                    reg_wr_i,
   input  wire                    reg_rd_i,
   output reg  [7:0]              reg_rdata_o,
   input  wire                    wdt_timeout_i,
   input  wire                    ext_reset_i,
   input  wire                    serial_download_i,
   input  wire [7:0]              high_voltage_config_i,
   input  wire [7:0]              high_voltage_status_i,
   input  wire [`RSMR_ADDR_W-1:0] cpu_addr_i,
   output wire                    sel_sram_o,
   output wire                    sel_flash_o,
   output wire                    vector_hit_o,
   output wire                    sys_reset_o,
   output wire                    wdt_reset_o,
   output wire                    core_run_o,
   output reg                     ram_valid_o
);
   // ----------------------------------------------------------------
   // Reset sources
   // ----------------------------------------------------------------
   reg  [7:0] map_r;
   reg  [3:0] sta_r;
   reg        dl_seen_r;
   reg        por_cfg_r;
   wire       wr_map;
   wire       wr_sta;
   wire       wr_clr;
   wire       sw_req;
   wire       sys_busy;
   wire       any_src;
   wire       cfg_done;
   assign wr_map = reg_wr_i && (reg_addr_i == `RSMR_ADDR_MAP);
   assign wr_sta = reg_wr_i && (reg_addr_i == `RSMR_ADDR_STA);
   assign wr_clr = reg_wr_i && (reg_addr_i == `RSMR_ADDR_CLR);
   assign sw_req = (wr_sta && reg_wdata_i[`RSMR_BIT_SW]) ||
                   (wr_clr && sta_r[`RSMR_BIT_SW] && !reg_wdata_i[`RSMR_BIT_SW]);
   assign any_src = sw_req || wdt_timeout_i || ext_reset_i;
   rsmr_pulse_stretch u_stretch (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .req_i      (any_src),
      .busy_o     (sys_busy)
   );
   // Every source, power-on included, yields the same system reset.
   assign sys_reset_o = reset_i || sys_busy;
   // The watchdog keeps counting through warm resets so a hung loop still trips.
   assign wdt_reset_o = reset_i;
   rsmr_cfg_timer u_cfg (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .hold_i     (sys_busy),
      .done_o     (cfg_done)
   );
   // Core leaves the configuration routine and fetches from address zero.
   assign core_run_o = cfg_done;
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         map_r <= `RSMR_ZERO8;
      end else if (any_src || sys_busy) begin
         map_r <= `RSMR_ZERO8;
      end else if (wr_map) begin
         map_r <= reg_wdata_i;
      end
   end
   // Set wins over clear so a source arriving with a clear write is kept.
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_sta
         wire set_b;
         if (g == `RSMR_BIT_POR) begin : g_por
            assign set_b = 1'b0;
         end else if (g == `RSMR_BIT_WDT) begin : g_wdt
            assign set_b = wdt_timeout_i;
         end else if (g == `RSMR_BIT_SW) begin : g_sw
            assign set_b = sw_req;
         end else begin : g_ext
            assign set_b = ext_reset_i;
         end
         always @(posedge core_clk_i or posedge reset_i) begin
            if (reset_i) begin
               sta_r[g] <= (g == `RSMR_BIT_POR);
            end else if (set_b) begin
               sta_r[g] <= 1'b1;
            end else if (wr_clr && reg_wdata_i[g]) begin
               sta_r[g] <= 1'b0;
            end
         end
      end
   endgenerate
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         reg_rdata_o <= `RSMR_ZERO8;
      end else if (reg_rd_i && reg_addr_i == `RSMR_ADDR_MAP) begin
         reg_rdata_o <= map_r;
      end else if (reg_rd_i && reg_addr_i == `RSMR_ADDR_STA) begin
         reg_rdata_o <= {4'h0, sta_r};
      end else begin
         reg_rdata_o <= `RSMR_ZERO8;
      end
   end
   // ----------------------------------------------------------------
   // Remap decode
   // ----------------------------------------------------------------
   wire low_hit;
   assign low_hit      = (cpu_addr_i < `RSMR_LOW_LIMIT);
   assign sel_sram_o   = low_hit && map_r[`RSMR_BIT_REMAP];
   assign sel_flash_o  = low_hit && !map_r[`RSMR_BIT_REMAP];
   // Vectors are served by whichever memory the low decode selects.
   assign vector_hit_o = (cpu_addr_i <= `RSMR_VEC_TOP);
   // ----------------------------------------------------------------
   // RAM validity
   // ----------------------------------------------------------------
   // Status bit 0 outlives warm resets, so the power-on phase keeps its own marker.
   // A download is remembered until the next reset has used it.
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         dl_seen_r   <= 1'b0;
         por_cfg_r   <= 1'b1;
         ram_valid_o <= 1'b0;
      end else begin
         if (serial_download_i) begin
            dl_seen_r <= 1'b1;
         end else if (!sys_busy && !cfg_done) begin
            dl_seen_r <= 1'b0;
         end
         if (sys_busy || cfg_done) begin
            por_cfg_r <= 1'b0;
         end
         if (sys_busy) begin
            ram_valid_o <= !dl_seen_r;
         end else if (!cfg_done && por_cfg_r) begin
            ram_valid_o <= high_voltage_config_i[`RSMR_BIT_LVF_EN] &&
                           high_voltage_status_i[`RSMR_BIT_LVF_OK];
         end
      end
   end
endmodule

// file: rsmr_defines.vh
// Purpose: Constants for the reset source and memory remap block.
// Assumes: Register port with word addresses equal to the printed byte offsets.
// Notes:   Included by every design file of the block.
// Notes on behaviour
// - Vector region follows memory mapped at zero.
// - Remap bit set selects SRAM, clear flash.
// - Every reset clears the remap bit.
// - Reset runs configuration routine, then vector zero.
// - Status bits record power-on, watchdog, external resets.
// - Writing status bit 2 starts software reset.
// - Status bits seven to four read zero.
// - Writing one to clear register clears status.
// - Clear write keeping software bit restarts reset.
// - Every reset kind resets pins, peripherals, registers; here the status register and wdt_reset_o are reset by power-on only.
// - RAM valid except after serial-link download reset.
// - Power-on RAM validity follows low-voltage flag.
`ifndef RSMR_DEFINES_VH
`define RSMR_DEFINES_VH
`define RSMR_ADDR_W        32
`define RSMR_ADDR_MAP      32'hFFFF0220
`define RSMR_ADDR_STA      32'hFFFF0230
`define RSMR_ADDR_CLR      32'hFFFF0234
`define RSMR_BIT_REMAP     0
`define RSMR_BIT_POR       0
`define RSMR_BIT_WDT       1
`define RSMR_BIT_SW        2
`define RSMR_BIT_EXT       3
`define RSMR_BIT_LVF_EN    4
`define RSMR_BIT_LVF_OK    2
`define RSMR_STA_MASK      8'h0F
`define RSMR_ZERO8         8'h00
`define RSMR_VEC_TOP       32'h00000020
`define RSMR_LOW_LIMIT     32'h00010000
// Time for the hidden configuration routine, in ns, and its cycle count at 10 MHz.
`define RSMR_CFG_TIME_NS   1600
`define RSMR_CLK_NS        100
`define RSMR_CFG_CYCLES    ((`RSMR_CFG_TIME_NS + `RSMR_CLK_NS - 1) / `RSMR_CLK_NS)
`define RSMR_CNT_W         5
`define RSMR_RST_HOLD      5'h02
// Absolute flash address; software runs its remap code from here.
`define RSMR_FLASH_ABS     32'h00080000
`endif

// file: rsmr_pulse_stretch.v
// Purpose: Stretches a one-cycle request into a fixed-length reset pulse.
// Assumes: Request is synchronous to the clock.
// Notes:   Used for the internal system reset of each source.
`timescale 1ns/10ps
`include "rsmr_defines.vh"
module rsmr_pulse_stretch (
   input  wire       core_clk_i,
   input  wire       reset_i,
   input  wire       req_i,
   output wire       busy_o
);
   reg [`RSMR_CNT_W-1:0] cnt_r;
   wire [`RSMR_CNT_W-1:0] cnt_nxt;
   assign cnt_nxt = req_i ? `RSMR_RST_HOLD :
                    (cnt_r != {`RSMR_CNT_W{1'b0}}) ? cnt_r - 1'b1 : cnt_r;
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_r <= {`RSMR_CNT_W{1'b0}};
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   assign busy_o = (cnt_r != {`RSMR_CNT_W{1'b0}});
endmodule

// file: rsmr_cfg_timer.v
// Purpose: Holds the core in the hidden configuration routine after a reset.
// Assumes: Start is a level that stays high while any reset is active.
// Notes:   Done rises a fixed number of cycles after start falls.
`timescale 1ns/10ps
`include "rsmr_defines.vh"
module rsmr_cfg_timer (
   input  wire       core_clk_i,
   input  wire       reset_i,
   input  wire       hold_i,
   output reg        done_o
);
   localparam integer CFG_LAST = `RSMR_CFG_CYCLES - 1;
   reg [`RSMR_CNT_W-1:0] cnt_r;
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_r  <= {`RSMR_CNT_W{1'b0}};
         done_o <= 1'b0;
      end else if (hold_i) begin
         cnt_r  <= {`RSMR_CNT_W{1'b0}};
         done_o <= 1'b0;
      end else if (cnt_r == CFG_LAST[`RSMR_CNT_W-1:0]) begin
         done_o <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 1'b1;
      end
   end
endmodule

// file: rsmr_assertions.sv
// Purpose: Port checker for the reset source and remap block.
// Assumes: Sees only the ports of rsmr_top.
// Notes:   Warm resets show as a stretched pulse on sys_reset_o.
`timescale 1ns/10ps
`include "rsmr_defines.vh"
module rsmr_assertions (
   input wire        core_clk_i,
   input wire        reset_i,
   input wire [31:0] reg_addr_i,
   input wire [7:0]  reg_wdata_i,
   input wire        reg_wr_i,
   input wire        reg_rd_i,
   input wire [7:0]  reg_rdata_o,
   input wire        wdt_timeout_i,
   input wire        ext_reset_i,
   input wire [31:0] cpu_addr_i,
   input wire        sel_sram_o,
   input wire        sel_flash_o,
   input wire        vector_hit_o,
   input wire        sys_reset_o,
   input wire        wdt_reset_o,
   input wire        core_run_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   wire sw_wr = reg_wr_i && reg_addr_i == `RSMR_ADDR_STA && reg_wdata_i[2];
   wire map_wr = reg_wr_i && reg_addr_i == `RSMR_ADDR_MAP && !sys_reset_o;
   a_vector_span:
      assert property (vector_hit_o == (cpu_addr_i <= 32'h20)) else $error("vector decode");
   a_remap_follows:
      assert property (map_wr |=> sys_reset_o || cpu_addr_i >= 32'h10000
         || sel_sram_o == $past(reg_wdata_i[0])) else $error("remap select");
   a_reset_flash:
      assert property ($rose(sys_reset_o) |=> cpu_addr_i != 0 || sel_flash_o)
         else $error("flash not at zero after reset");
   a_cfg_then_run:
      assert property ($fell(sys_reset_o) |-> !core_run_o ##[1:20] core_run_o)
         else $error("core run timing");
   a_sw_reset_start:
      assert property (sw_wr && !sys_reset_o |=> sys_reset_o [*2]) else $error("sw reset");
   a_status_upper_zero:
      assert property (reg_rd_i && reg_addr_i == `RSMR_ADDR_STA |=> reg_rdata_o[7:4] == 4'h0)
         else $error("status upper bits");
   a_source_resets:
      assert property (wdt_timeout_i || ext_reset_i |=> sys_reset_o) else $error("source reset");
   a_wdt_por_only:
      assert property (wdt_timeout_i |=> !wdt_reset_o [*3]) else $error("watchdog reset");
   c_sw: cover property (sw_wr);
   c_wdt: cover property (wdt_timeout_i);
   c_run: cover property ($fell(sys_reset_o) ##[1:20] core_run_o);
endmodule
bind rsmr_top rsmr_assertions u_rsmr_assertions (.core_clk_i, .reset_i, .reg_addr_i,
   .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .wdt_timeout_i, .ext_reset_i, .cpu_addr_i,
   .sel_sram_o, .sel_flash_o, .vector_hit_o, .sys_reset_o, .wdt_reset_o, .core_run_o);

// file: rsmr_src_model.sv
// Purpose: Model of the watchdog and external pin reset sources.
// Assumes: Requests come from the bench after a clock edge.
// Notes:   A held request gives a one-cycle pulse on every second cycle, not a level.
`timescale 1ns/10ps
module rsmr_src_model (
   input  wire core_clk_i,
   input  wire wdt_req_i,
   input  wire ext_req_i,
   output reg  wdt_timeout_o = 1'b0,
   output reg  ext_reset_o = 1'b0
);
   always @(posedge core_clk_i) begin
      wdt_timeout_o <= wdt_req_i & ~wdt_timeout_o;
      ext_reset_o   <= ext_req_i & ~ext_reset_o;
   end
endmodule

// file: reset_source_and_memory_remap_tb.sv
// Purpose: Self-checking bench for the reset source and remap block.
// Assumes: Software writes zero to reserved map bits.
// Notes:   Hand tests after the decode table cover every reset kind.
`timescale 1ns/10ps
`include "rsmr_defines.vh"
module reset_source_and_memory_remap_tb;
   reg         core_clk_i = 1'b0;
   reg         reset_i = 1'b1;
   reg  [31:0] reg_addr_i = 32'h0;
   reg  [31:0] cpu_addr_i = 32'h0;
   reg  [7:0]  reg_wdata_i = 8'h00;
   reg         reg_wr_i = 1'b0;
   reg         reg_rd_i = 1'b0;
   reg         wdt_req = 1'b0;
   reg         ext_req = 1'b0;
   reg         serial_download_i = 1'b0;
   // Low-voltage flag enabled and reporting intact RAM until the last power-on test.
   reg  [7:0]  high_voltage_config_i = 8'h10;
   reg  [7:0]  high_voltage_status_i = 8'h04;
   wire [7:0]  reg_rdata_o;
   wire        wdt_timeout_i, ext_reset_i, sel_sram_o, sel_flash_o, vector_hit_o;
   wire        sys_reset_o, wdt_reset_o, core_run_o, ram_valid_o;
   integer     n_mismatch = 0, n_compared = 0, i, n;
   reg  [35:0] rows [0:5];
   always #50 core_clk_i = ~core_clk_i;
   rsmr_src_model u_rsmr_src_model (.core_clk_i, .wdt_req_i(wdt_req), .ext_req_i(ext_req),
      .wdt_timeout_o(wdt_timeout_i), .ext_reset_o(ext_reset_i));
   rsmr_top u_rsmr_top (.core_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .wdt_timeout_i, .ext_reset_i, .serial_download_i,
      .high_voltage_config_i, .high_voltage_status_i, .cpu_addr_i, .sel_sram_o,
      .sel_flash_o, .vector_hit_o, .sys_reset_o, .wdt_reset_o, .core_run_o, .ram_valid_o);
   task chk(input [63:0] name, input [7:0] exp, input [7:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %0s: expected %h seen %h", name, exp, got);
         end
      end
   endtask
   task wr(input [31:0] a, input [7:0] d);
      begin
         @(posedge core_clk_i);
         reg_addr_i <= a;
         reg_wdata_i <= d;
         reg_wr_i <= 1'b1;
         @(posedge core_clk_i);
         reg_wr_i <= 1'b0;
      end
   endtask
   task rd(input [31:0] a, input [7:0] exp, input [63:0] name);
      begin
         @(posedge core_clk_i);
         reg_addr_i <= a;
         reg_rd_i <= 1'b1;
         @(posedge core_clk_i);
         reg_rd_i <= 1'b0;
         #1 chk(name, exp, reg_rdata_o);
      end
   endtask
   // Waits out the configuration routine; the bound keeps a stuck core from hanging us.
   task wait_run;
      begin
         repeat (4) @(posedge core_clk_i);
         n = 4;
         while (core_run_o !== 1'b1 && n < 100) begin
            @(posedge core_clk_i);
            n = n + 1;
         end
         chk("run", 8'h01, {7'h0, core_run_o});
      end
   endtask
   task fire(input w, input e);
      begin
         @(posedge core_clk_i);
         wdt_req <= w;
         ext_req <= e;
         @(posedge core_clk_i);
         wdt_req <= 1'b0;
         ext_req <= 1'b0;
         wait_run;
      end
   endtask
   task tally_and_finish;
      begin
         $display("compared %0d mismatched %0d", n_compared, n_mismatch);
         if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   initial begin
      #(100 * 5000);
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
   end
   initial begin
      rows[0] = {1'b0, 32'h0, 3'b011};
      rows[1] = {1'b1, 32'h20, 3'b101};
      rows[2] = {1'b1, 32'h21, 3'b100};
      rows[3] = {1'b1, 32'hFFFF, 3'b100};
      rows[4] = {1'b0, 32'h10000, 3'b000};
      rows[5] = {1'b1, 32'h40000, 3'b000};
      repeat (2) @(posedge core_clk_i);
      reset_i <= 1'b0;
      wait_run;
      chk("cfg", 8'h01, {7'h0, n > 8});
      rd(`RSMR_ADDR_STA, 8'h01, "status");
      rd(`RSMR_ADDR_MAP, 8'h00, "map");
      chk("ram", 8'h01, {7'h0, ram_valid_o});
      for (i = 0; i < 6; i = i + 1) begin
         cpu_addr_i <= `RSMR_FLASH_ABS;
         wr(`RSMR_ADDR_MAP, {7'h00, rows[i][35]});
         cpu_addr_i <= rows[i][34:3];
         @(posedge core_clk_i);
         #1 chk("decode", {5'h0, rows[i][2:0]}, {5'h0, sel_sram_o, sel_flash_o, vector_hit_o});
      end
      cpu_addr_i <= 32'h0;
      fire(1'b1, 1'b0);
      rd(`RSMR_ADDR_MAP, 8'h00, "map");
      chk("flash", 8'h01, {7'h0, sel_flash_o});
      rd(`RSMR_ADDR_STA, 8'h03, "status");
      chk("wdt rst", 8'h00, {7'h0, wdt_reset_o});
      fire(1'b0, 1'b1);
      rd(`RSMR_ADDR_STA, 8'h0B, "status");
      chk("ram", 8'h01, {7'h0, ram_valid_o});
      wr(`RSMR_ADDR_CLR, 8'h0B);
      rd(`RSMR_ADDR_STA, 8'h00, "status");
      wr(`RSMR_ADDR_STA, 8'h04);
      wait_run;
      rd(`RSMR_ADDR_STA, 8'h04, "status");
      wr(`RSMR_ADDR_CLR, 8'h01);
      #1 chk("restart", 8'h01, {7'h0, sys_reset_o});
      wait_run;
      wr(`RSMR_ADDR_CLR, 8'h04);
      #1 chk("no rst", 8'h00, {7'h0, sys_reset_o});
      rd(`RSMR_ADDR_STA, 8'h00, "status");
      rd(32'hFFFF0238, 8'h00, "unmapped");
      @(posedge core_clk_i);
      serial_download_i <= 1'b1;
      @(posedge core_clk_i);
      serial_download_i <= 1'b0;
      fire(1'b0, 1'b1);
      chk("ram", 8'h00, {7'h0, ram_valid_o});
      // Second power-on reset in mid-run, with the flag now reporting corrupted RAM.
      cpu_addr_i <= `RSMR_FLASH_ABS;
      wr(`RSMR_ADDR_MAP, 8'h01);
      high_voltage_status_i <= 8'h00;
      @(posedge core_clk_i);
      reset_i <= 1'b1;
      @(posedge core_clk_i);
      #1 chk("wdt rst", 8'h01, {7'h0, wdt_reset_o});
      chk("sys rst", 8'h01, {7'h0, sys_reset_o});
      @(posedge core_clk_i);
      reset_i <= 1'b0;
      wait_run;
      chk("ram", 8'h00, {7'h0, ram_valid_o});
      rd(`RSMR_ADDR_MAP, 8'h00, "map");
      rd(`RSMR_ADDR_STA, 8'h01, "status");
      tally_and_finish;
   end
endmodule
